// >>> rtl/ial_pkg.sv
// package for the nt layer 1 activation controller
package ial_pkg;
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
   // t2 window in ms
   localparam int unsigned T2_MIN_MS      = 25;
   localparam int unsigned T2_MAX_MS      = 100;
   localparam int unsigned T2_DEF_MS      = 25;
   // t1 supervisory default, ms
   localparam int unsigned T1_DEF_MS      = 30000;
   // optional info 4 hold-off after info 3
   localparam int unsigned HOLD_MS        = 100;
   // response limits
   localparam int unsigned INFO2_RESP_MS  = 1000;
   localparam int unsigned INFO4_RESP_MS  = 500;
   localparam int unsigned DEACT_RESP_MS  = 25;
   localparam int unsigned T2_MIN_CYC     = T2_MIN_MS * CYC_PER_MS;
   localparam int unsigned T2_MAX_CYC     = T2_MAX_MS * CYC_PER_MS;
   localparam int unsigned T2_DEF_CYC     = T2_DEF_MS * CYC_PER_MS;
   localparam int unsigned T1_DEF_CYC     = T1_DEF_MS * CYC_PER_MS;
   localparam int unsigned HOLD_CYC       = HOLD_MS * CYC_PER_MS;
   localparam int unsigned TMR_W          = 32;

   // line signal levels
   typedef enum logic [2:0] {
      IAL_INFO0 = 3'h0,
      IAL_INFO1 = 3'h1,
      IAL_INFO2 = 3'h2,
      IAL_INFO3 = 3'h3,
      IAL_INFO4 = 3'h4
   } ial_info_e;

   // one-cycle primitive events toward upper layers
   typedef struct packed {
      logic ph_act;
      logic ph_deact;
      logic mph_act;
      logic mph_deact;
      logic mph_err;
   } ial_ind_s;

   // one-cycle requests from management / layer 2
   typedef struct packed {
      logic ph_act;
      logic mph_deact;
   } ial_req_s;
endpackage : ial_pkg

// >>> rtl/ial_timer.sv
// one-shot down counter timer
`timescale 1ns/1ns
`default_nettype none
module ial_timer #(
   parameter int unsigned W = 32
) (
   // clock and reset
   input  wire logic         ref_clk_in,
   input  wire logic         rst_n_in,
   // control
   input  wire logic         start_in,
   input  wire logic         stop_in,
   input  wire logic [W-1:0] load_in,
   // status
   output logic              run_out,
   output logic              expire_out
);
   logic [W-1:0] cnt_q;
   logic         run_q;
   logic         exp_q;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end else if (stop_in) begin
         run_q <= 1'b0;
      end else if (start_in) begin
         cnt_q <= load_in;
         run_q <= (load_in != '0);
      end else if (run_q) begin
         cnt_q <= cnt_q - 1'b1;
         if (cnt_q == {{(W-1){1'b0}}, 1'b1})
            run_q <= 1'b0;
      end
   end

   // expiry pulse; a zero load expires at once
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         exp_q <= 1'b0;
      else
         exp_q <= !stop_in && ((start_in && load_in == '0) ||
                  (!start_in && run_q && cnt_q == {{(W-1){1'b0}}, 1'b1}));
   end

   assign run_out    = run_q;
   assign expire_out = exp_q;
endmodule : ial_timer
`default_nettype wire

// >>> rtl/ial_sync.sv
// three-stage synchroniser for a multi-bit level with agreement check
`timescale 1ns/1ns
`default_nettype none
module ial_sync #(
   parameter int unsigned W = 3
) (
   // clock and reset
   input  wire logic         ref_clk_in,
   input  wire logic         rst_n_in,
   // level
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         out_q <= '0;
      else if (s2_q == s3_q)
         out_q <= s3_q;
   end

   assign sync_out = out_q;
endmodule : ial_sync
`default_nettype wire

// >>> rtl/ial_nt_ctrl.sv
// nt layer 1 activation / deactivation controller
// Functional notes
// - primitives are one-cycle events consumed when seen, info signals are held levels.
// - timer t1 bounds the whole activation of exchange side and terminal side.
// - timer t2 blocks unwanted reactivation and is limited to 25 ms through 100 ms.
// - with unambiguous info 1 detection t2 may be zero so deactivate goes straight to g1.
// - deactivation and error indications to management may be switched off.
// - optionally info 4 and activation indications wait 100 ms after info 3.
// - in g1 on info 1 the nt sends info 2 within 1 s (30 s abnormal).
// - in g2 on info 3 the nt sends info 4 within 500 ms (15 s abnormal, 30 s total).
// - on info 0 or lost framing the nt sends info 2 within 25 ms.
// - info 0 from a terminal never deactivates the nt.
`timescale 1ns/1ns
`default_nettype none
module ial_nt_ctrl
   import ial_pkg::*;
#(
   parameter int unsigned T1_CYC    = ial_pkg::T1_DEF_CYC,
   parameter int unsigned T2_CYC    = ial_pkg::T2_DEF_CYC,
   parameter int unsigned HOLD_CYCS = ial_pkg::HOLD_CYC
) (
   // clock and reset
   input  wire logic               ref_clk_in,
   input  wire logic               rst_n_in,
   // line receiver, asynchronous level
   input  wire ial_pkg::ial_info_e rx_info_in,
   input  wire logic               rx_frame_lost_in,
   // exchange side ready (network synchronised)
   input  wire logic               net_sync_in,
   // requests from upper layers
   input  wire ial_pkg::ial_req_s  req_in,
   // options
   input  wire logic               t2_zero_in,
   input  wire logic               hold_en_in,
   input  wire logic               mgmt_ind_en_in,
   // line transmitter level
   output ial_pkg::ial_info_e      tx_info_out,
   // indications
   output ial_pkg::ial_ind_s       ind_out,
   output logic [1:0]              state_out
);
   import ial_pkg::*;

   typedef enum logic [1:0] { G1_DEACT, G2_PEND, G3_ACT, G4_PDEACT } ial_state_e;

   ial_state_e         st_q;
   ial_info_e          tx_q;
   ial_ind_s           ind_q;
   logic [2:0]         rx_raw;
   ial_info_e          rx;
   logic [1:0]         lost_sync;
   logic               lost;
   logic               net_ok;
   logic               act_go;
   logic               t1_start;
   logic               t1_stop;
   logic               t1_exp;
   logic               t2_start;
   logic               t2_run;
   logic               t2_exp;
   logic               hold_start;
   logic               hold_exp;
   logic               hold_done_q;
   logic               in3_q;
   logic [TMR_W-1:0]   t2_load;

   // clamp t2 into its legal window unless the zero option is chosen
   function automatic logic [TMR_W-1:0] t2_value(input logic zero);
      int unsigned v;
      v = T2_CYC;
      if (v < T2_MIN_CYC)
         v = T2_MIN_CYC;
      if (v > T2_MAX_CYC)
         v = T2_MAX_CYC;
      return zero ? '0 : TMR_W'(v);
   endfunction : t2_value

   // info 3 on the line with framing held and the exchange side ready
   function automatic logic info3_ok(input ial_info_e r, input logic ls, input logic ns);
      return (r == IAL_INFO3) && !ls && ns;
   endfunction : info3_ok

   // line inputs from outside the clock domain
   ial_sync #(.W(3)) u_rx_sync (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .async_in   (rx_info_in),
      .sync_out   (rx_raw)
   );

   ial_sync #(.W(2)) u_lost_sync (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .async_in   ({rx_frame_lost_in, net_sync_in}),
      .sync_out   (lost_sync)
   );

   assign rx      = ial_info_e'(rx_raw);
   assign lost    = lost_sync[1];
   // exchange readiness is a pin level too, so only the synchronised copy is used
   assign net_ok  = lost_sync[0];
   assign t2_load = t2_value(t2_zero_in);

   ial_timer #(.W(TMR_W)) u_t1 (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .start_in   (t1_start),
      .stop_in    (t1_stop),
      .load_in    (TMR_W'(T1_CYC)),
      .run_out    (),
      .expire_out (t1_exp)
   );

   ial_timer #(.W(TMR_W)) u_t2 (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .start_in   (t2_start),
      .stop_in    (1'b0),
      .load_in    (t2_load),
      .run_out    (t2_run),
      .expire_out (t2_exp)
   );

   ial_timer #(.W(TMR_W)) u_hold (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .start_in   (hold_start),
      .stop_in    (st_q != G2_PEND),
      .load_in    (TMR_W'(HOLD_CYCS)),
      .run_out    (),
      .expire_out (hold_exp)
   );

   // t1 runs from activation start until g3 or g4 is entered; a direct deactivation from g2 to g1 leaves it running
   assign t1_start = (st_q == G1_DEACT) &&
                     (req_in.ph_act || rx == IAL_INFO1) && !t2_run;
   assign t1_stop  = (st_q == G3_ACT) || (st_q == G4_PDEACT);
   assign t2_start = req_in.mph_deact && (st_q == G2_PEND || st_q == G3_ACT);
   assign hold_start = (st_q == G2_PEND) && (rx == IAL_INFO3) && !in3_q && hold_en_in;
   // activation completes this cycle; shared by the state move and its indications
   assign act_go = (st_q == G2_PEND) && info3_ok(rx, lost, net_ok) && !req_in.mph_deact &&
                   (!hold_en_in || hold_done_q);

   // info 3 seen, level tracking for hold-off start
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         in3_q <= 1'b0;
      else
         in3_q <= (st_q == G2_PEND) && (rx == IAL_INFO3);
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         hold_done_q <= 1'b0;
      else if (st_q != G2_PEND)
         hold_done_q <= 1'b0;
      else if (hold_exp)
         hold_done_q <= 1'b1;
   end

   // state machine; deactivation only by management request
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= G1_DEACT;
      end else begin
         unique case (st_q)
            G1_DEACT: begin
               if (t1_start)
                  st_q <= G2_PEND;
            end
            G2_PEND: begin
               if (req_in.mph_deact)
                  st_q <= t2_zero_in ? G1_DEACT : G4_PDEACT;
               else if (act_go)
                  st_q <= G3_ACT;
            end
            G3_ACT: begin
               if (req_in.mph_deact)
                  st_q <= t2_zero_in ? G1_DEACT : G4_PDEACT;
               else if (!info3_ok(rx, lost, 1'b1))
                  st_q <= G2_PEND;
            end
            G4_PDEACT: begin
               if (t2_exp || (!t2_run && rx == IAL_INFO0))
                  st_q <= G1_DEACT;
            end
         endcase
      end
   end

   // transmitted line level follows the state
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_q <= IAL_INFO0;
      end else begin
         unique case (st_q)
            G1_DEACT:  tx_q <= IAL_INFO0;
            G2_PEND:   tx_q <= net_ok ? IAL_INFO2 : IAL_INFO0;
            G3_ACT:    tx_q <= !info3_ok(rx, lost, 1'b1) ? IAL_INFO2 : IAL_INFO4;
            G4_PDEACT: tx_q <= IAL_INFO0;
         endcase
      end
   end

   // primitives as one-cycle events
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ind_q <= '0;
      end else begin
         ind_q          <= '0;
         ind_q.ph_act   <= act_go;
         ind_q.mph_act  <= act_go;
         ind_q.ph_deact <= (st_q != G1_DEACT) &&
                           ((t1_exp && st_q == G2_PEND) || t2_start);
         ind_q.mph_deact <= mgmt_ind_en_in && t1_exp && (st_q == G2_PEND);
         ind_q.mph_err   <= mgmt_ind_en_in && (st_q == G3_ACT) &&
                            !req_in.mph_deact && lost;
      end
   end

   assign tx_info_out = tx_q;
   assign ind_out     = ind_q;
   assign state_out   = st_q;
endmodule : ial_nt_ctrl
`default_nettype wire

// >>> sim/ial_nt_chk_assertions.sv
// assertions on the nt activation controller ports
`timescale 1ns/1ns
`default_nettype none
module ial_nt_chk
   import ial_pkg::*;
#(
   parameter int unsigned T1_CYC    = 1000,
   parameter int unsigned T2_CYC    = 250000,
   parameter int unsigned HOLD_CYCS = 50
) (
   // clock and reset
   input wire logic               ref_clk_in,
   input wire logic               rst_n_in,
   // watched inputs
   input wire ial_pkg::ial_info_e rx_info_in,
   input wire logic               net_sync_in,
   input wire ial_pkg::ial_req_s  req_in,
   input wire logic               t2_zero_in,
   input wire logic               hold_en_in,
   input wire logic               mgmt_ind_en_in,
   // watched outputs
   input wire ial_pkg::ial_info_e tx_info_out,
   input wire ial_pkg::ial_ind_s  ind_out,
   input wire logic [1:0]         state_out
);
   logic [31:0] g2_cnt_q;
   // cycles in pending activation with info 3 standing on the line
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         g2_cnt_q <= '0;
      end else begin
         g2_cnt_q <= (state_out == 2'h1 && rx_info_in == IAL_INFO3) ? g2_cnt_q + 32'h1 : 32'h0;
      end
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_pulse; ind_out.ph_act |=> !ind_out.ph_act; endproperty
   a_pulse: assert property (p_pulse) else $error("activation pulse too long");
   property p_info2; $rose(state_out == 2'h1) && net_sync_in |=> tx_info_out == IAL_INFO2;
   endproperty
   a_info2: assert property (p_info2) else $error("no info2 in g2");
   property p_act;
      $rose(state_out == 2'h2) |-> ind_out.ph_act && ind_out.mph_act ##1 tx_info_out == IAL_INFO4;
   endproperty
   a_act: assert property (p_act) else $error("g3 entry without info4");
   property p_stay; state_out == 2'h2 && !req_in.mph_deact |=> state_out inside {2'h1, 2'h2};
   endproperty
   a_stay: assert property (p_stay) else $error("g3 left without request");
   property p_direct;
      state_out inside {2'h1, 2'h2} && req_in.mph_deact && t2_zero_in |=> state_out == 2'h0;
   endproperty
   a_direct: assert property (p_direct) else $error("no direct move to g1");
   property p_pend;
      state_out inside {2'h1, 2'h2} && req_in.mph_deact && !t2_zero_in |=> state_out == 2'h3;
   endproperty
   a_pend: assert property (p_pend) else $error("no pending deactivation");
   property p_mgmt;
      !mgmt_ind_en_in && !$past(mgmt_ind_en_in) && !$past(mgmt_ind_en_in, 2)
         |-> !ind_out.mph_deact && !ind_out.mph_err;
   endproperty
   a_mgmt: assert property (p_mgmt) else $error("management indication while off");
   property p_hold; hold_en_in && $rose(state_out == 2'h2) |-> g2_cnt_q >= HOLD_CYCS;
   endproperty
   a_hold: assert property (p_hold) else $error("info4 hold-off too short");
   c_g3: cover property ($rose(state_out == 2'h2));
   c_pend: cover property (state_out == 2'h3);
   c_err: cover property (ind_out.mph_err);
endmodule : ial_nt_chk
bind ial_nt_ctrl ial_nt_chk #(.T1_CYC(T1_CYC), .T2_CYC(T2_CYC), .HOLD_CYCS(HOLD_CYCS)) u_chk (
   .ref_clk_in, .rst_n_in, .rx_info_in, .net_sync_in, .req_in, .t2_zero_in, .hold_en_in,
   .mgmt_ind_en_in, .tx_info_out, .ind_out, .state_out);
`default_nettype wire

// >>> sim/ial_te_model.sv
// terminal side model answering the nt line levels
`timescale 1ns/1ns
`default_nettype none
module ial_te_model
   import ial_pkg::*;
(
   input  wire logic               ref_clk_in,
   input  wire logic               rst_n_in,
   // high asks for activation
   input  wire logic               act_in,
   input  wire ial_pkg::ial_info_e nt_info_in,
   output ial_pkg::ial_info_e      te_info_out
);
   // levels held continuously, except info 0 after info 3, which lasts one cycle while act_in is high
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         te_info_out <= IAL_INFO0;
      end else if (!act_in || nt_info_in == IAL_INFO0 && te_info_out == IAL_INFO3) begin
         te_info_out <= IAL_INFO0;
      end else if (nt_info_in == IAL_INFO2 || nt_info_in == IAL_INFO4) begin
         te_info_out <= IAL_INFO3;
      end else begin
         te_info_out <= IAL_INFO1;
      end
   end
endmodule : ial_te_model
`default_nettype wire

// >>> sim/isdn_basic_l1_activation_timing_tb.sv
// bench for the nt activation controller against a terminal model
`timescale 1ns/1ns
`default_nettype none
module isdn_basic_l1_activation_timing_tb;
   import ial_pkg::*;
   localparam int unsigned T1C = 1000;
   localparam int unsigned HC  = 50;
   logic       ref_clk_in  = 1'b0;
   logic       rst_n_in    = 1'b0;
   logic       act         = 1'b0;
   logic       lost        = 1'b0;
   logic       nsync       = 1'b0;
   logic       t2z         = 1'b0;
   logic       hold        = 1'b0;
   logic       mgi         = 1'b1;
   ial_req_s   req         = '0;
   ial_info_e  rx;
   ial_info_e  tx;
   ial_ind_s   ind;
   logic [4:0] ind_v;
   logic [1:0] st;
   int         n_mismatch  = 0;
   int         checks_done = 0;
   int         cnt[5]      = '{default: 0};
   assign ind_v = ind;
   always #50 ref_clk_in = ~ref_clk_in;
   // pulse counters: 4 act, 3 deact, 2 mgmt act, 1 mgmt deact, 0 error
   always @(posedge ref_clk_in) begin
      for (int i = 0; i < 5; i++) begin
         cnt[i] <= cnt[i] + int'(ind_v[i] === 1'b1);
      end
   end
   ial_te_model TE (.ref_clk_in, .rst_n_in, .act_in(act), .nt_info_in(tx), .te_info_out(rx));
   ial_nt_ctrl #(.T1_CYC(T1C), .HOLD_CYCS(HC)) DUT (.ref_clk_in, .rst_n_in, .rx_info_in(rx),
      .rx_frame_lost_in(lost), .net_sync_in(nsync), .req_in(req), .t2_zero_in(t2z),
      .hold_en_in(hold), .mgmt_ind_en_in(mgi), .tx_info_out(tx), .ind_out(ind), .state_out(st));
   task automatic chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   task automatic chki(input string nm, input int exp, input int got);
      checks_done++;
      if (got != exp) begin
         n_mismatch++;
         $display("ERROR %s expected %0d seen %0d", nm, exp, got);
      end
   endtask : chki
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask : tick
   task automatic wait_st(input logic [1:0] s, input int max, output int n);
      for (n = 0; n < max && st !== s; n++) begin
         tick(1);
      end
   endtask : wait_st
   task automatic pulse_deact();
      @(posedge ref_clk_in);
      req.mph_deact <= 1'b1;
      @(posedge ref_clk_in);
      req.mph_deact <= 1'b0;
      #1;
   endtask : pulse_deact
   task automatic t_t1_expiry();
      int n;
      int c;
      int m;
      c = cnt[3];
      m = cnt[1];
      @(posedge ref_clk_in);
      act <= 1'b1;
      wait_st(2'h1, 20, n);
      chk("g2 on info1", 3'h1, {1'b0, st});
      tick(T1C + 20);
      chki("t1 deact ind", c + 1, cnt[3]);
      chki("t1 mgmt deact ind", m + 1, cnt[1]);
      chk("g2 after t1", 3'h1, {1'b0, st});
   endtask : t_t1_expiry
   task automatic t_activate(input logic h);
      int n;
      int c;
      int m;
      c = cnt[4];
      m = cnt[2];
      @(posedge ref_clk_in);
      nsync <= 1'b1;
      hold  <= h;
      for (n = 0; n < 20 && tx !== IAL_INFO2; n++) begin
         tick(1);
      end
      chk("info2 sent", IAL_INFO2, tx);
      wait_st(2'h2, HC + 40, n);
      chk("g3 reached", 3'h2, {1'b0, st});
      chki("hold span", 1, int'(!h || n >= HC));
      tick(1);
      chk("info4 sent", IAL_INFO4, tx);
      chki("act ind", c + 1, cnt[4]);
      chki("mgmt act ind", m + 1, cnt[2]);
   endtask : t_activate
   task automatic t_info0();
      int n;
      @(posedge ref_clk_in);
      act  <= 1'b0;
      hold <= 1'b0;
      wait_st(2'h1, 20, n);
      tick(2);
      chk("no deact on info0", 3'h1, {1'b0, st});
      chk("info2 on info0", IAL_INFO2, tx);
      @(posedge ref_clk_in);
      act <= 1'b1;
   endtask : t_info0
   task automatic t_loss();
      int c;
      c = cnt[0];
      @(posedge ref_clk_in);
      lost <= 1'b1;
      tick(8);
      chk("g2 on loss", 3'h1, {1'b0, st});
      chk("info2 on loss", IAL_INFO2, tx);
      chki("error ind", c + 1, cnt[0]);
      @(posedge ref_clk_in);
      lost <= 1'b0;
   endtask : t_loss
   task automatic t_deact();
      int n;
      int c;
      int e;
      wait_st(2'h2, 20, n);
      c = cnt[1];
      e = cnt[0];
      // frame loss in g3 with management indications switched off
      @(posedge ref_clk_in);
      mgi  <= 1'b0;
      lost <= 1'b1;
      tick(8);
      chki("mgmt err off", e, cnt[0]);
      @(posedge ref_clk_in);
      lost <= 1'b0;
      t2z  <= 1'b1;
      wait_st(2'h2, 20, n);
      pulse_deact();
      chk("direct to g1", 3'h0, {1'b0, st});
      @(posedge ref_clk_in);
      req.ph_act <= 1'b1;
      @(posedge ref_clk_in);
      req.ph_act <= 1'b0;
      #1;
      chk("g2 on act req", 3'h1, {1'b0, st});
      chki("mgmt ind off", c, cnt[1]);
      @(posedge ref_clk_in);
      mgi <= 1'b1;
      t2z <= 1'b0;
      wait_st(2'h2, 60, n);
      pulse_deact();
      chk("pending deact", 3'h3, {1'b0, st});
   endtask : t_deact
   task automatic final_report();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (10) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      t_t1_expiry();
      t_activate(1'b1);
      t_info0();
      t_activate(1'b0);
      t_loss();
      t_deact();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      n_mismatch++;
      final_report();
   end
endmodule : isdn_basic_l1_activation_timing_tb
`default_nettype wire
